//--- hdl/rxq_qualifier.sv
// Contract
// - IP destination checked only when bit 4 set
// - MAC destination checked only when bit 3 set
// - Layer 2 format detected only when bit 2
// - UDP/IPv6 format detected only when bit 1
// - UDP/IPv4 format detected only when bit 0
// - Domain must match field when match enabled
// - Alternate master flag must be zero if enabled
// - Bad UDP checksum blocks unless check disabled
// - Bad FCS blocks unless check disabled
// - Version must match field; zero accepts any
// - Message type enable bit gates timestamping
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rxq_qualifier (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    input  wire logic [8:0]               addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [31:0]              rdata_o,
    input  wire rxq_pkg::rxq_frame_s      frame_i,
    output logic                          stamp_o,
    output logic                          filter_ok_o
);

    // Configuration and status state
    logic                  ptp_en;        // Global unit enable
    logic [4:0]            parse_cfg;     // Format and address checks
    rxq_pkg::rxq_ts_cfg_s  ts_cfg;        // Timestamp qualification
    logic [15:0]           stamp_cnt;     // Frames stamped so far
    logic                  next_ptp_en;
    logic [4:0]            next_parse_cfg;
    rxq_pkg::rxq_ts_cfg_s  next_ts_cfg;
    logic [15:0]           next_stamp_cnt;

    // Output state
    logic [31:0]           next_rdata;
    logic                  next_stamp;    // Stamp pulse for the next cycle
    logic                  next_filter_ok; // Filter permit for the next cycle
    rxq_pkg::rxq_verdict_s verdict;       // Combinational verdict
    logic                  fire;          // Frame arrives while enabled

    // Qualify one parsed frame against the configuration
    function automatic rxq_pkg::rxq_verdict_s qualify(
        input rxq_pkg::rxq_frame_s  fr,
        input logic [4:0]           pc,
        input rxq_pkg::rxq_ts_cfg_s tc
    );
        rxq_pkg::rxq_verdict_s v;
        logic fmt_ok;
        logic addr_ok;
        logic sum_ok;
        logic fld_ok;
        v = '0;
        // Format enables
        case (fr.fmt)
            rxq_pkg::RXQ_FMT_L2:   fmt_ok = pc[rxq_pkg::L2_DET_BIT];
            rxq_pkg::RXQ_FMT_UDP4: fmt_ok = pc[rxq_pkg::UDP4_BIT];
            rxq_pkg::RXQ_FMT_UDP6: fmt_ok = pc[rxq_pkg::UDP6_BIT];
            default:               fmt_ok = 1'b0;
        endcase
        // Destination addresses, IP only for UDP formats
        addr_ok = (!pc[rxq_pkg::MAC_CHK_BIT] || fr.mac_dest_ok)
                && (fr.fmt == rxq_pkg::RXQ_FMT_L2 || !pc[rxq_pkg::IP_CHK_BIT]
                    || fr.ip_dest_ok);
        // Integrity, UDP checksum only for UDP formats
        sum_ok = (tc.fcs_dis || fr.fcs_ok)
               && (fr.fmt == rxq_pkg::RXQ_FMT_L2 || tc.udp_dis
                   || fr.udp_sum_ok);
        // Header field checks
        fld_ok = (!tc.domain_en || fr.domain == tc.domain)
               && (!tc.alt_en || !fr.alt_master)
               && (tc.version == rxq_pkg::VER_ANY
                   || fr.version == tc.version)
               && tc.type_en[fr.msg_type];
        v.filter_ok = fr.valid && fmt_ok && sum_ok;
        v.stamp     = v.filter_ok && addr_ok && fld_ok;
        return v;
    endfunction

    // Frame seen while the unit is enabled
    assign fire = ce_i && frame_i.valid && ptp_en;

    // Verdict for the current frame
    always_comb begin
        verdict = qualify(frame_i, parse_cfg, ts_cfg);
    end

    // Register writes, counter and read mux
    always_comb begin
        next_ptp_en    = ptp_en;
        next_parse_cfg = parse_cfg;
        next_ts_cfg    = ts_cfg;
        next_stamp_cnt = stamp_cnt;
        next_rdata     = 32'h0000_0000;
        // Verdicts only while the unit is enabled
        next_stamp     = ptp_en && verdict.stamp;
        next_filter_ok = ptp_en && verdict.filter_ok;
        // Host stays off config while enabled; no lockout here
        if (wr_i) begin
            case (addr_i)
                rxq_pkg::OFF_CMD_CTL: begin
                    next_ptp_en = wdata_i[rxq_pkg::CMD_EN_BIT];
                end
                rxq_pkg::OFF_PARSE_CFG: begin
                    next_parse_cfg = wdata_i[4:0];
                end
                rxq_pkg::OFF_TS_CFG: begin
                    next_ts_cfg = wdata_i;
                end
                rxq_pkg::OFF_STAMP_CNT: begin
                    next_stamp_cnt = rxq_pkg::CNT_RST;
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        // Stamp after a clear still counts
        if (ptp_en && verdict.stamp) begin
            next_stamp_cnt = next_stamp_cnt + 16'h0001;
        end
        // Read data for the next cycle only
        if (rd_i) begin
            case (addr_i)
                rxq_pkg::OFF_CMD_CTL:   next_rdata = {31'h0000_0000, ptp_en};
                rxq_pkg::OFF_PARSE_CFG: next_rdata = {27'h000_0000, parse_cfg};
                rxq_pkg::OFF_TS_CFG:    next_rdata = ts_cfg;
                rxq_pkg::OFF_STAMP_CNT: next_rdata = {16'h0000, stamp_cnt};
                default:                next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ptp_en      <= rxq_pkg::CMD_RST;
            parse_cfg   <= rxq_pkg::PARSE_RST;
            ts_cfg      <= rxq_pkg::TS_RST;
            stamp_cnt   <= rxq_pkg::CNT_RST;
            rdata_o     <= 32'h0000_0000;
            stamp_o     <= 1'b0;
            filter_ok_o <= 1'b0;
        end else if (ce_i) begin
            ptp_en      <= next_ptp_en;
            parse_cfg   <= next_parse_cfg;
            ts_cfg      <= next_ts_cfg;
            stamp_cnt   <= next_stamp_cnt;
            rdata_o     <= next_rdata;
            stamp_o     <= next_stamp;
            filter_ok_o <= next_filter_ok;
        end
    end

    // Checks on the verdict outputs and the stamp counter
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ip_check;
        fire && frame_i.fmt != rxq_pkg::RXQ_FMT_L2 && parse_cfg[rxq_pkg::IP_CHK_BIT]
            && !frame_i.ip_dest_ok |=> !stamp_o;
    endproperty
    a_ip_check: assert property (p_ip_check) else $error("IP destination not checked");

    property p_mac_check;
        fire && parse_cfg[rxq_pkg::MAC_CHK_BIT] && !frame_i.mac_dest_ok |=> !stamp_o;
    endproperty
    a_mac_check: assert property (p_mac_check) else $error("MAC destination not checked");

    property p_l2_detect;
        fire && frame_i.fmt == rxq_pkg::RXQ_FMT_L2 && !parse_cfg[rxq_pkg::L2_DET_BIT]
            |=> !stamp_o && !filter_ok_o;
    endproperty
    a_l2_detect: assert property (p_l2_detect) else $error("Layer 2 frame taken while disabled");

    property p_udp6_detect;
        fire && frame_i.fmt == rxq_pkg::RXQ_FMT_UDP6 && !parse_cfg[rxq_pkg::UDP6_BIT]
            |=> !stamp_o && !filter_ok_o;
    endproperty
    a_udp6_detect: assert property (p_udp6_detect) else $error("IPv6 frame taken while disabled");

    property p_udp4_detect;
        fire && frame_i.fmt == rxq_pkg::RXQ_FMT_UDP4 && !parse_cfg[rxq_pkg::UDP4_BIT]
            |=> !stamp_o && !filter_ok_o;
    endproperty
    a_udp4_detect: assert property (p_udp4_detect) else $error("IPv4 frame taken while disabled");

    property p_domain;
        fire && ts_cfg.domain_en && frame_i.domain != ts_cfg.domain |=> !stamp_o;
    endproperty
    a_domain: assert property (p_domain) else $error("Domain mismatch stamped");

    property p_alt_master;
        fire && ts_cfg.alt_en && frame_i.alt_master |=> !stamp_o;
    endproperty
    a_alt_master: assert property (p_alt_master) else $error("Alternate master stamped");

    property p_udp_sum;
        fire && frame_i.fmt != rxq_pkg::RXQ_FMT_L2 && !ts_cfg.udp_dis && !frame_i.udp_sum_ok
            |=> !stamp_o && !filter_ok_o;
    endproperty
    a_udp_sum: assert property (p_udp_sum) else $error("Bad UDP checksum passed");

    property p_fcs;
        fire && !ts_cfg.fcs_dis && !frame_i.fcs_ok |=> !stamp_o && !filter_ok_o;
    endproperty
    a_fcs: assert property (p_fcs) else $error("Bad FCS passed");

    property p_version;
        fire && ts_cfg.version != rxq_pkg::VER_ANY && frame_i.version != ts_cfg.version
            |=> !stamp_o;
    endproperty
    a_version: assert property (p_version) else $error("Version mismatch stamped");

    property p_type_en;
        fire && !ts_cfg.type_en[frame_i.msg_type] |=> !stamp_o;
    endproperty
    a_type_en: assert property (p_type_en) else $error("Disabled message type stamped");

    property p_stamp_cause;
        stamp_o |-> $past(frame_i.valid) && $past(ptp_en) && filter_ok_o;
    endproperty
    a_stamp_cause: assert property (p_stamp_cause) else $error("Stamp without qualified frame");

    property p_counter;
        stamp_o && $past(ce_i) && !($past(wr_i) && $past(addr_i) == rxq_pkg::OFF_STAMP_CNT)
            |-> stamp_cnt == $past(stamp_cnt) + 16'h0001;
    endproperty
    a_counter: assert property (p_counter) else $error("Stamp counter missed a stamp");

    // Main scenarios
    c_stamp_udp4: cover property (fire && frame_i.fmt == rxq_pkg::RXQ_FMT_UDP4 ##1 stamp_o);
    c_stamp_udp6: cover property (fire && frame_i.fmt == rxq_pkg::RXQ_FMT_UDP6 ##1 stamp_o);
    c_stamp_l2:   cover property (fire && frame_i.fmt == rxq_pkg::RXQ_FMT_L2 ##1 stamp_o);
    c_filter_only: cover property (filter_ok_o && !stamp_o);

endmodule

`default_nettype wire

//--- include/rxq_pkg.sv
package rxq_pkg;

    // Register port widths
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [8:0] OFF_CMD_CTL   = 9'h100;
    localparam logic [8:0] OFF_PARSE_CFG = 9'h158;
    localparam logic [8:0] OFF_TS_CFG    = 9'h15C;
    localparam logic [8:0] OFF_STAMP_CNT = 9'h1F0;

    // Command control field positions
    localparam int CMD_EN_BIT = 0;

    // Parsing configuration field positions
    localparam int IP_CHK_BIT  = 4;
    localparam int MAC_CHK_BIT = 3;
    localparam int L2_DET_BIT  = 2;
    localparam int UDP6_BIT    = 1;
    localparam int UDP4_BIT    = 0;
    localparam int PARSE_W     = 5;

    // Values after reset, and the version value that accepts any
    localparam logic [4:0]  PARSE_RST = 5'h1F;
    localparam logic [31:0] TS_RST    = 32'h0002_0000;
    localparam logic        CMD_RST   = 1'h0;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [3:0]  VER_ANY   = 4'h0;

    // Transport format reported by the receive parser
    typedef enum logic [1:0] {
        RXQ_FMT_NONE = 2'b00,
        RXQ_FMT_L2   = 2'b01,
        RXQ_FMT_UDP4 = 2'b10,
        RXQ_FMT_UDP6 = 2'b11
    } rxq_fmt_e;

    // Parsed header summary of one received frame
    typedef struct packed {
        logic       valid;       // One-cycle pulse per frame
        rxq_fmt_e   fmt;         // Transport format
        logic       mac_dest_ok; // Destination MAC is a PTP address
        logic       ip_dest_ok;  // Destination IP is a PTP address
        logic [7:0] domain;      // Message domain number
        logic       alt_master;  // Alternate master flag
        logic [3:0] version;     // Message version
        logic [3:0] msg_type;    // Message type
        logic       udp_sum_ok;  // UDP checksum valid
        logic       fcs_ok;      // Frame check sequence valid
    } rxq_frame_s;

    // Timestamp configuration word, bit 31 first
    typedef struct packed {
        logic [7:0]  domain;     // Bits 31:24
        logic        domain_en;  // Bit 23
        logic        alt_en;     // Bit 22
        logic        udp_dis;    // Bit 21
        logic        fcs_dis;    // Bit 20
        logic [3:0]  version;    // Bits 19:16
        logic [15:0] type_en;    // Bits 15:0
    } rxq_ts_cfg_s;

    // Qualification verdict
    typedef struct packed {
        logic stamp;             // Record ingress time
        logic filter_ok;         // Filtering may act
    } rxq_verdict_s;

endpackage

//--- verification/rxq_ptp_node.sv
`timescale 1ns/1ps
`default_nettype none
// Remote node model: hands one parsed frame summary per call
module rxq_ptp_node (
    input  wire logic                 ref_clk_i,
    output var  rxq_pkg::rxq_frame_s  frame_o
);
    // Quiet bus before any frame
    initial frame_o = '0;
    // One-cycle valid pulse, then fields scrambled so stale data never looks good
    task automatic send(input rxq_pkg::rxq_frame_s f);
        rxq_pkg::rxq_frame_s g;
        g = f;
        g.valid = 1'b1;
        @(posedge ref_clk_i);
        frame_o <= g;
        g = ~f;
        g.valid = 1'b0;
        @(posedge ref_clk_i);
        frame_o <= g;
    endtask
endmodule
`default_nettype wire

//--- verification/rxq_qualifier_test.sv
`timescale 1ns/1ps
`default_nettype none
module rxq_qualifier_test;
    logic                ref_clk_i;    // Core clock
    logic                rst_i;        // Synchronous reset
    logic                ce_i;         // Clock enable, high except during one write in t_reset
    logic [8:0]          addr_i;       // Register address
    logic [31:0]         wdata_i;      // Write data
    logic                wr_i;         // Write strobe
    logic                rd_i;         // Read strobe
    logic [31:0]         rdata_o;      // Read data
    logic                stamp_o;      // Ingress stamp pulse
    logic                filter_ok_o;  // Filter permit pulse
    rxq_pkg::rxq_frame_s frame_i;      // Frame summary from node model
    rxq_pkg::rxq_frame_s f;            // Scratch frame
    int                  err_count;    // Mismatches
    int                  checks;       // Comparisons

    rxq_qualifier i_rxq_qualifier (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frame_i(frame_i),
        .stamp_o(stamp_o), .filter_ok_o(filter_ok_o));
    rxq_ptp_node i_rxq_ptp_node (.ref_clk_i(ref_clk_i), .frame_o(frame_i));

    // 40 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read, data judged in the following cycle
    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
        @(posedge ref_clk_i);
        #1;
        chk(rdata_o, 32'h0000_0000);
    endtask

    // Reconfigure only with the unit disabled
    task automatic cfg(input logic [4:0] pc, input logic [31:0] tc);
        wr(rxq_pkg::OFF_CMD_CTL, 32'h0000_0000);
        wr(rxq_pkg::OFF_PARSE_CFG, {27'h0, pc});
        wr(rxq_pkg::OFF_TS_CFG, tc);
        wr(rxq_pkg::OFF_CMD_CTL, 32'h0000_0001);
    endtask

    // Send a frame and judge both pulses one cycle later
    task automatic try(input rxq_pkg::rxq_frame_s fr, input logic es, input logic ef);
        i_rxq_ptp_node.send(fr);
        #1;
        chk({30'h0, stamp_o, filter_ok_o}, {30'h0, es, ef});
        @(posedge ref_clk_i);
        #1;
        chk({30'h0, stamp_o, filter_ok_o}, 32'h0000_0000);
    endtask

    // A UDP/IPv4 frame that passes every check
    function automatic rxq_pkg::rxq_frame_s good();
        good = '0;
        good.fmt = rxq_pkg::RXQ_FMT_UDP4;
        good.mac_dest_ok = 1'b1;
        good.ip_dest_ok = 1'b1;
        good.version = 4'h2;
        good.udp_sum_ok = 1'b1;
        good.fcs_ok = 1'b1;
    endfunction

    // Reset values and an unmapped read
    task automatic t_reset();
        rd(rxq_pkg::OFF_PARSE_CFG, 32'h0000_001F);
        rd(rxq_pkg::OFF_TS_CFG, 32'h0002_0000);
        rd(rxq_pkg::OFF_CMD_CTL, 32'h0000_0000);
        rd(9'h0F4, 32'h0000_0000);
        // A write with the clock enable low is lost
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        wr(rxq_pkg::OFF_PARSE_CFG, 32'h0000_0000);
        ce_i <= 1'b1;
        rd(rxq_pkg::OFF_PARSE_CFG, 32'h0000_001F);
        $display("test reset done");
    endtask

    // Each format gated by its own enable bit
    task automatic t_format();
        rxq_pkg::rxq_fmt_e fm [3];
        fm = '{rxq_pkg::RXQ_FMT_UDP4, rxq_pkg::RXQ_FMT_UDP6, rxq_pkg::RXQ_FMT_L2};
        f = good();
        for (int b = 0; b < 3; b++) begin
            f.fmt = fm[b];
            cfg(5'h1F & ~(5'h01 << b), 32'h0002_FFFF);
            try(f, 1'b0, 1'b0);
            cfg(5'h1F, 32'h0002_FFFF);
            try(f, 1'b1, 1'b1);
        end
        f.fmt = rxq_pkg::RXQ_FMT_NONE;
        try(f, 1'b0, 1'b0);
        wr(rxq_pkg::OFF_CMD_CTL, 32'h0000_0000);
        try(good(), 1'b0, 1'b0);
        $display("test format done");
    endtask

    // Destination checks follow bits 4 and 3
    task automatic t_addr();
        cfg(5'h1F, 32'h0002_FFFF);
        f = good();
        f.mac_dest_ok = 1'b0;
        try(f, 1'b0, 1'b1);
        f = good();
        f.ip_dest_ok = 1'b0;
        try(f, 1'b0, 1'b1);
        cfg(5'h07, 32'h0002_FFFF);
        rd(rxq_pkg::OFF_PARSE_CFG, 32'h0000_0007);
        rd(rxq_pkg::OFF_CMD_CTL, 32'h0000_0001);
        try(f, 1'b1, 1'b1);
        f.mac_dest_ok = 1'b0;
        try(f, 1'b1, 1'b1);
        $display("test address done");
    endtask

    // Domain, alternate flag, version and type gates
    task automatic t_fields();
        cfg(5'h1F, 32'h5AC2_800F);
        f = good();
        f.domain = 8'h5A;
        for (int t = 0; t < 4; t++) begin
            f.msg_type = t[3:0];
            try(f, 1'b1, 1'b1);
        end
        f.msg_type = 4'hF;
        try(f, 1'b1, 1'b1);
        f.msg_type = 4'h4;
        try(f, 1'b0, 1'b1);
        f.msg_type = 4'h0;
        f.domain = 8'h5B;
        try(f, 1'b0, 1'b1);
        f.domain = 8'h5A;
        f.alt_master = 1'b1;
        try(f, 1'b0, 1'b1);
        f.alt_master = 1'b0;
        f.version = 4'h3;
        try(f, 1'b0, 1'b1);
        cfg(5'h1F, 32'h5A00_000F);
        f.domain = 8'h5B;
        f.alt_master = 1'b1;
        f.version = 4'h7;
        try(f, 1'b1, 1'b1);
        $display("test fields done");
    endtask

    // Integrity checks and their bypass bits, with the stamp count
    task automatic t_integ();
        cfg(5'h1F, 32'h0002_000F);
        wr(rxq_pkg::OFF_STAMP_CNT, 32'h0000_0000);
        f = good();
        f.udp_sum_ok = 1'b0;
        try(f, 1'b0, 1'b0);
        f.fmt = rxq_pkg::RXQ_FMT_L2;
        try(f, 1'b1, 1'b1);
        f = good();
        f.fcs_ok = 1'b0;
        try(f, 1'b0, 1'b0);
        cfg(5'h1F, 32'h0032_000F);
        rd(rxq_pkg::OFF_TS_CFG, 32'h0032_000F);
        try(f, 1'b1, 1'b1);
        f = good();
        f.udp_sum_ok = 1'b0;
        try(f, 1'b1, 1'b1);
        rd(rxq_pkg::OFF_STAMP_CNT, 32'h0000_0003);
        // Stamp in the same cycle as the clear still counts after it
        fork
            i_rxq_ptp_node.send(f);
            wr(rxq_pkg::OFF_STAMP_CNT, 32'h0000_0000);
        join
        rd(rxq_pkg::OFF_STAMP_CNT, 32'h0000_0001);
        $display("test integrity done");
    endtask

    // Reset in mid-run restores the defaults
    task automatic t_rst2();
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(rxq_pkg::OFF_TS_CFG, 32'h0002_0000);
        rd(rxq_pkg::OFF_STAMP_CNT, 32'h0000_0000);
        rd(rxq_pkg::OFF_CMD_CTL, 32'h0000_0000);
        try(good(), 1'b0, 1'b0);
        $display("test reset again done");
    endtask

    // Counts and verdict
    task automatic finish_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        err_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        err_count = 0;
        checks = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 9'h000;
        wdata_i = 32'h0000_0000;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_format();
        t_addr();
        t_fields();
        t_integ();
        t_rst2();
        finish_test();
    end
endmodule
`default_nettype wire
